// ===== bench/spiee_master_model.sv
// Bus master model driving the EEPROM pins in clock mode 0.
// Assumes its tasks are called from one bench process.
`default_nettype none
module spiee_master_model (
    input wire logic i_clk_sys,
    input wire logic i_miso,
    input wire logic i_miso_oe,
    output logic o_sclk,
    output logic o_cs_b,
    output logic o_mosi,
    output logic o_hold_b,
    output logic o_wp_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line_reg;
    int oe_cnt;
    int hold_oe;
    // Undriven data line flips every cycle, so a missing enable cannot pass
    always @(posedge i_clk_sys) begin
        line_reg <= i_miso_oe ? i_miso : ~line_reg;
    end
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b0;
        o_mosi = 1'b0;
        o_hold_b = 1'b1;
        o_wp_b = 1'b1;
        line_reg = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tick
    task automatic set_wp(input logic v);
        tick(1);
        o_wp_b <= v;
    endtask : set_wp
    task automatic sel();
        tick(1);
        o_cs_b <= 1'b0;
        oe_cnt = 0;
        hold_oe = 0;
        tick(4);
    endtask : sel
    task automatic desel();
        tick(4);
        o_cs_b <= 1'b1;
        o_mosi <= ~o_mosi;
        tick(4);
    endtask : desel
    task automatic xfer(input logic [7:0] d, input int n, input int hold_at,
                        output logic [7:0] q);
        q = 8'h00;
        for (int i = 0; i < n; i++) begin
            if (i == hold_at) begin
                tick(1);
                o_hold_b <= 1'b0;
                tick(6);
                repeat (2) begin
                    o_sclk <= 1'b1;
                    o_mosi <= ~o_mosi;
                    tick(4);
                    hold_oe += int'(i_miso_oe);
                    o_sclk <= 1'b0;
                    tick(4);
                end
                o_hold_b <= 1'b1;
                tick(4);
            end
            o_mosi <= d[7 - i];
            tick(4);
            o_sclk <= 1'b1;
            tick(4);
            q = {q[6:0], line_reg};
            oe_cnt += int'(i_miso_oe);
            o_sclk <= 1'b0;
        end
    endtask : xfer
endmodule : spiee_master_model
`default_nettype wire

// ===== bench/spiee_top_properties.sv
// Concurrent checks on the pins of the serial EEPROM front end.
// Assumes pins change on system clock edges, as the bench drives them.
`default_nettype none
module spiee_top_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_mosi,
    input wire logic i_hold_b,
    input wire logic i_wp_b,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic o_standby,
    input wire logic o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic armed_reg;
    logic paused_reg;
    logic [3:0] since_edge_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed_reg <= 1'b0;
            paused_reg <= 1'b0;
            since_edge_reg <= 4'hf;
        end else begin
            armed_reg <= armed_reg | $fell(i_cs_b);
            paused_reg <= !(i_cs_b || i_hold_b) && (paused_reg || ($fell(i_hold_b) && !i_sclk));
            // Resuming from a pause may re-drive the output, so it counts too
            if ($fell(i_sclk) || $rose(i_hold_b)) begin
                since_edge_reg <= 4'h0;
            end else if (since_edge_reg != 4'hf) begin
                since_edge_reg <= since_edge_reg + 4'h1;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_oe_off_desel: assert property (i_cs_b [*5] |-> !o_miso_oe)
        else $error("data out driven while deselected");
    a_oe_off_hold: assert property (paused_reg [*5] |-> !o_miso_oe)
        else $error("data out driven while paused");
    a_oe_needs_arm: assert property (!armed_reg |-> !o_miso_oe)
        else $error("data out driven before first select fall");
    a_oe_rise_sel: assert property ($rose(o_miso_oe) |-> !i_cs_b && i_hold_b)
        else $error("data out enabled while deselected or paused");
    a_miso_after_fall: assert property (o_miso_oe && $past(o_miso_oe) && $changed(o_miso)
        |-> since_edge_reg inside {[0:6]})
        else $error("data out changed away from a falling clock edge");
    a_standby_sel: assert property ((armed_reg && !i_cs_b) [*5] |-> !o_standby)
        else $error("standby while selected");
    a_standby_idle: assert property ((i_cs_b && !o_busy) [*8] |-> o_standby)
        else $error("no standby while deselected and idle");
    a_busy_no_stby: assert property (o_busy && $past(o_busy) |-> !o_standby)
        else $error("standby during write cycle");
    a_busy_on_desel: assert property ($rose(o_busy) |-> i_cs_b)
        else $error("write cycle started while selected");
    c_write_cycle: cover property ($rose(o_busy));
    c_paused_clock: cover property (paused_reg && i_sclk);
    c_read_out: cover property ($rose(o_miso_oe));
endmodule : spiee_top_checker

bind spiee_top spiee_top_checker u_checker (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_ce(i_ce), .i_sclk(i_sclk), .i_cs_b(i_cs_b), .i_mosi(i_mosi), .i_hold_b(i_hold_b),
    .i_wp_b(i_wp_b), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_standby(o_standby),
    .o_busy(o_busy));
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the serial EEPROM pin front end.
// Assumes the master model owns every serial pin; clock enable stays high.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 40000;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic sclk, cs_b, mosi, hold_b, wp_b, miso, miso_oe, standby, busy, busy_seen;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [47:0] rx;
    always #25 i_clk_sys = ~i_clk_sys;
    spiee_top u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_sclk(sclk),
        .i_cs_b(cs_b), .i_mosi(mosi), .i_hold_b(hold_b), .i_wp_b(wp_b), .o_miso(miso),
        .o_miso_oe(miso_oe), .o_standby(standby), .o_busy(busy));
    spiee_master_model u_master (.i_clk_sys(i_clk_sys), .i_miso(miso), .i_miso_oe(miso_oe),
        .o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi), .o_hold_b(hold_b), .o_wp_b(wp_b));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // One framed transfer; bytes leave from the top of tx, hold at byte hb bit hbit
    task automatic run(input logic [47:0] tx, input int n, input int hb, input int hbit,
                       input bit sb);
        logic [7:0] q;
        u_master.sel();
        for (int i = 0; i < n; i++) begin
            u_master.xfer(tx[47 - 8 * i -: 8], 8, (i == hb) ? hbit : -1, q);
            rx = {rx[39:0], q};
        end
        if (sb) check("standby_sel", {7'h0, standby}, 8'h00);
        u_master.desel();
        busy_seen = 1'b0;
        repeat (12) begin
            @(posedge i_clk_sys);
            busy_seen |= (busy === 1'b1);
        end
    endtask : run
    task automatic wren();
        run(48'h06_0000000000, 1, -1, 0, 1);
    endtask : wren
    task automatic wait_idle(input bit want_busy);
        for (int k = 0; k < 500 && busy === 1'b1; k++) begin
            @(posedge i_clk_sys);
        end
        if (want_busy) check("busy_seen", {7'h0, busy_seen}, 8'h01);
        check("busy_end", {7'h0, busy}, 8'h00);
        check("standby_idle", {7'h0, standby}, 8'h01);
    endtask : wait_idle
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_unarmed();
        run(48'h03_0000_0000_00, 5, -1, 0, 0);
        check("oe_unarmed", 8'(u_master.oe_cnt), 8'h00);
    endtask : t_unarmed
    task automatic t_write_read();
        wren();
        run(48'h02_07fe_a53c_00, 5, -1, 0, 1);
        wait_idle(1);
        run(48'h03_07fe_0000_00, 5, -1, 0, 1);
        check("rd_7fe", rx[15:8], 8'ha5);
        check("rd_7ff", rx[7:0], 8'h3c);
    endtask : t_write_read
    task automatic t_partial();
        logic [7:0] q;
        u_master.sel();
        u_master.xfer(8'hff, 4, -1, q);
        u_master.desel();
        run(48'h03_07ff_00_0000, 4, -1, 0, 1);
        check("rd_after_partial", rx[7:0], 8'h3c);
    endtask : t_partial
    task automatic t_hold();
        run(48'h03_07fe_0000_00, 5, 0, 5, 1);
        check("rd_hold_cmd", rx[7:0], 8'h3c);
        run(48'h03_07fe_0000_00, 5, 3, 3, 1);
        check("rd_hold_data", rx[15:8], 8'ha5);
        check("oe_in_hold", 8'(u_master.hold_oe), 8'h00);
    endtask : t_hold
    task automatic t_idpage();
        wren();
        run(48'h82_001f_5a_0000, 4, -1, 0, 1);
        wait_idle(1);
        wren();
        run(48'h82_0400_00_0000, 4, -1, 0, 1);
        wait_idle(0);
        wren();
        run(48'h82_001f_c3_0000, 4, -1, 0, 1);
        wait_idle(0);
        run(48'h83_001f_00_0000, 4, -1, 0, 1);
        check("id_locked", rx[7:0], 8'h5a);
    endtask : t_idpage
    task automatic t_protect();
        wren();
        run(48'h01_8c_00000000, 2, -1, 0, 1);
        wait_idle(0);
        u_master.set_wp(1'b0);
        wren();
        run(48'h01_00_00000000, 2, -1, 0, 1);
        wait_idle(0);
        run(48'h05_00_00000000, 2, -1, 0, 1);
        check("bp_frozen", rx[7:0] & 8'h8c, 8'h8c);
        wren();
        run(48'h02_07fe_00_0000, 4, -1, 0, 1);
        wait_idle(0);
        run(48'h03_07fe_00_0000, 4, -1, 0, 1);
        check("rd_protected", rx[7:0], 8'ha5);
        u_master.set_wp(1'b1);
        wren();
        run(48'h01_00_00000000, 2, -1, 0, 1);
        wait_idle(0);
        run(48'h05_00_00000000, 2, -1, 0, 1);
        check("bp_cleared", rx[7:0] & 8'h8c, 8'h00);
    endtask : t_protect
    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        check("oe_reset", {7'h0, miso_oe}, 8'h00);
        check("standby_reset", {7'h0, standby}, 8'h01);
        check("busy_reset", {7'h0, busy}, 8'h00);
        repeat (2) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        t_unarmed();
        t_write_read();
        t_partial();
        t_hold();
        t_idpage();
        t_protect();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

// ===== hw/spiee_params.svh
// Constants of the serial EEPROM pin front end: opcodes, status bits, sizes.
// Assumes inclusion by bare name from the design file.
// Overview of operation
// - Main array holds 2048 bytes.
// - Extra 32-byte page, lockable to read-only.
// - Output bits change after falling clock edges.
// - Input bits captured on rising clock edges.
// - Select high deselects; output high impedance.
// - Deselected means standby unless write runs.
// - Select low makes device active.
// - No instruction before first select falling edge.
// - Pause suspends exchange, keeps bit progress.
// - Paused: output off, input and clock ignored.
// - Write-protect freezes block-protect size bits.
// - All transfers most significant bit first.
// - Pause begins only if clock already low.
`ifndef SPIEE_PARAMS_SVH
`define SPIEE_PARAMS_SVH
`define SPIEE_OP_WRSR 8'h01
`define SPIEE_OP_WRITE 8'h02
`define SPIEE_OP_READ 8'h03
`define SPIEE_OP_WRDI 8'h04
`define SPIEE_OP_RDSR 8'h05
`define SPIEE_OP_WREN 8'h06
`define SPIEE_OP_WRID 8'h82
`define SPIEE_OP_RDID 8'h83
`define SPIEE_MEM_DEPTH 2048
`define SPIEE_ID_DEPTH 32
`define SPIEE_FIFO_DEPTH 32
`define SPIEE_SR_SRWD 7
`define SPIEE_SR_BP_HI 3
`define SPIEE_SR_BP_LO 2
`define SPIEE_SR_WEL 1
`define SPIEE_SR_WIP 0
`define SPIEE_SR_NV_RST 3'h0
`define SPIEE_LOCK_BIT 10
`define SPIEE_QUARTER_BASE 11'h600
`define SPIEE_HALF_BASE 11'h400
`endif

// ===== hw/spiee_pkg.sv
// Types shared by the serial EEPROM pin front end.
// Assumes the constants header is on the include path.
`default_nettype none
package spiee_pkg;
    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR_HI, ST_ADDR_LO, ST_RDATA, ST_WDATA, ST_SR_W, ST_IGNORE
    } spiee_state_t;
    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic mosi;
        logic hold_b;
        logic wp_b;
    } spiee_pins_t;
    typedef struct packed {
        logic id_sel;
        logic [10:0] addr;
        logic [7:0] data;
    } spiee_wr_t;
endpackage : spiee_pkg
`default_nettype wire

// ===== hw/spiee_top.sv
// Serial EEPROM pin front end: pin sampling, shift engine, hold, protection,
// a write-data FIFO and the storage arrays.
// Assumes all pins come from another clock domain and the serial clock runs
// far slower than i_clk_sys (a few system cycles per serial phase).
`include "spiee_params.svh"
`default_nettype none

// ----------------------------------------
// Write-data FIFO
// ----------------------------------------
module spiee_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = `SPIEE_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] buf_mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] count_reg;
    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;

    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = buf_mem[rptr_reg];

    always_ff @(posedge i_clk_sys) begin
        if (i_ce && push) begin
            buf_mem[wptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else if (i_ce) begin
            if (i_clear) begin
                wptr_reg <= '0;
                rptr_reg <= '0;
                count_reg <= '0;
            end else begin
                wptr_reg <= push ? AW'(wptr_reg + 1'b1) : wptr_reg;
                rptr_reg <= pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
                count_reg <= (AW+1)'(count_reg + push - pop);
            end
        end
    end
endmodule : spiee_fifo

// ----------------------------------------
// Pin front end
// ----------------------------------------
module spiee_top import spiee_pkg::*; #(
    parameter int MEM_DEPTH = `SPIEE_MEM_DEPTH,
    parameter int ID_DEPTH = `SPIEE_ID_DEPTH,
    parameter int FIFO_DEPTH = `SPIEE_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_mosi,
    input wire logic i_hold_b,
    input wire logic i_wp_b,
    output logic o_miso,
    output logic o_miso_oe,
    output logic o_standby,
    output logic o_busy
);
    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    spiee_pins_t pins_s1_reg;
    spiee_pins_t pins_reg;
    logic sclk_prev_reg;
    logic cs_prev_reg;
    logic hold_prev_reg;
    wire spiee_pins_t pins_raw = '{sclk: i_sclk, cs_b: i_cs_b, mosi: i_mosi,
                                   hold_b: i_hold_b, wp_b: i_wp_b};

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Select resets low: a pin held low through reset must not look like a fall
            pins_s1_reg <= '{sclk: 1'b0, cs_b: 1'b0, mosi: 1'b0, hold_b: 1'b1, wp_b: 1'b1};
            pins_reg <= '{sclk: 1'b0, cs_b: 1'b0, mosi: 1'b0, hold_b: 1'b1, wp_b: 1'b1};
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
            hold_prev_reg <= 1'b1;
        end else if (i_ce) begin
            pins_s1_reg <= pins_raw;
            pins_reg <= pins_s1_reg;
            sclk_prev_reg <= pins_reg.sclk;
            cs_prev_reg <= pins_reg.cs_b;
            hold_prev_reg <= pins_reg.hold_b;
        end
    end

    // cs_prev resets low so a select held low through reset is no falling edge
    wire sclk_rise = pins_reg.sclk & ~sclk_prev_reg;
    wire sclk_fall = ~pins_reg.sclk & sclk_prev_reg;
    wire cs_fall = cs_prev_reg & ~pins_reg.cs_b;
    wire cs_rise = ~cs_prev_reg & pins_reg.cs_b;

    // ----------------------------------------
    // Selection, hold and shift engine state
    // ----------------------------------------
    logic armed_reg;
    logic hold_reg;
    logic drive_reg;
    logic tx_is_status;
    logic busy_reg;
    spiee_state_t state_reg;
    spiee_state_t state_next;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [10:0] addr_reg;
    logic id_sel_reg;
    logic is_sr_reg;
    logic load_req_reg;
    logic [7:0] tx_reg;
    logic [7:0] sr_new_reg;
    logic sr_pend_reg;
    logic pushed_reg;
    logic wel_reg;
    logic srwd_reg;
    logic [1:0] bp_reg;
    logic id_locked_reg;
    logic [7:0] main_mem [MEM_DEPTH];
    logic [7:0] id_mem [ID_DEPTH];

    wire hold_enter = hold_prev_reg & ~pins_reg.hold_b & ~pins_reg.sclk;
    wire selected = armed_reg & ~pins_reg.cs_b;
    wire live = selected & ~hold_reg;
    wire bit_rise = live & sclk_rise;
    wire byte_done = bit_rise & (bit_cnt_reg == 3'h7);
    wire [7:0] byte_in = {shift_reg, pins_reg.mosi};
    wire [7:0] status_byte = {srwd_reg, 3'h0, bp_reg, wel_reg, busy_reg};

    // Block-protect region check
    wire addr_protected = (bp_reg == 2'h3) ||
                          (bp_reg == 2'h2 && addr_reg >= `SPIEE_HALF_BASE) ||
                          (bp_reg == 2'h1 && addr_reg >= `SPIEE_QUARTER_BASE);
    wire wr_ok = id_sel_reg ? ~id_locked_reg : ~addr_protected;
    wire sr_frozen = srwd_reg & ~pins_reg.wp_b;

    // Write FIFO hookup; a full FIFO refuses further bytes
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire spiee_wr_t fifo_out;
    wire fifo_push = byte_done & (state_reg == ST_WDATA) & wr_ok & fifo_in_ready;
    wire spiee_wr_t fifo_in = '{id_sel: id_sel_reg, addr: addr_reg, data: byte_in};
    wire fifo_clear = cs_rise & ~busy_reg & ~(pushed_reg & (bit_cnt_reg == 3'h0)
                      & (state_reg == ST_WDATA));
    wire commit_wr = cs_rise & pushed_reg & (bit_cnt_reg == 3'h0)
                     & (state_reg == ST_WDATA) & ~busy_reg;
    wire drain = busy_reg & fifo_out_valid;
    wire drain_done = busy_reg & ~fifo_out_valid;
    wire drain_lock = fifo_out.id_sel & fifo_out.addr[`SPIEE_LOCK_BIT];
    wire [7:0] rd_byte = id_sel_reg ? id_mem[addr_reg[4:0]] : main_mem[addr_reg];

    spiee_fifo #(.WIDTH($bits(spiee_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_clear(fifo_clear),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(busy_reg),
        .o_out_data(fifo_out)
    );

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_CMD: begin
                if (busy_reg && byte_in != `SPIEE_OP_RDSR) begin
                    state_next = ST_IGNORE;
                end else if (byte_in == `SPIEE_OP_READ || byte_in == `SPIEE_OP_RDID) begin
                    state_next = ST_ADDR_HI;
                end else if ((byte_in == `SPIEE_OP_WRITE || byte_in == `SPIEE_OP_WRID)
                             && wel_reg) begin
                    state_next = ST_ADDR_HI;
                end else if (byte_in == `SPIEE_OP_RDSR) begin
                    state_next = ST_RDATA;
                end else if (byte_in == `SPIEE_OP_WRSR && wel_reg) begin
                    state_next = ST_SR_W;
                end else begin
                    state_next = ST_IGNORE;
                end
            end
            ST_ADDR_HI: state_next = ST_ADDR_LO;
            ST_ADDR_LO: state_next = is_sr_reg ? ST_WDATA : ST_RDATA;
            ST_RDATA: state_next = ST_RDATA;
            ST_WDATA: state_next = ST_WDATA;
            ST_SR_W: state_next = ST_IGNORE;
            ST_IGNORE: state_next = ST_IGNORE;
        endcase
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed_reg <= 1'b0;
            hold_reg <= 1'b0;
            drive_reg <= 1'b0;
            state_reg <= ST_CMD;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
        end else if (i_ce) begin
            armed_reg <= armed_reg | cs_fall;
            // Remembers that the read phase drives, so a pause can hand the pin back
            drive_reg <= pins_reg.cs_b ? 1'b0 : (drive_reg | o_miso_oe);
            hold_reg <= pins_reg.cs_b ? 1'b0 :
                        (hold_enter ? 1'b1 : (pins_reg.hold_b ? 1'b0 : hold_reg));
            if (pins_reg.cs_b) begin
                state_reg <= ST_CMD;
                bit_cnt_reg <= 3'h0;
            end else if (bit_rise) begin
                bit_cnt_reg <= 3'(bit_cnt_reg + 1'b1);
                shift_reg <= byte_in[6:0];
                state_reg <= byte_done ? state_next : state_reg;
            end
        end
    end

    // Address, read loading and pending status/write bookkeeping
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            addr_reg <= 11'h000;
            id_sel_reg <= 1'b0;
            is_sr_reg <= 1'b0;
            load_req_reg <= 1'b0;
            tx_reg <= 8'h00;
            sr_new_reg <= 8'h00;
            sr_pend_reg <= 1'b0;
            pushed_reg <= 1'b0;
        end else if (i_ce) begin
            load_req_reg <= 1'b0;
            if (cs_rise) begin
                sr_pend_reg <= 1'b0;
                pushed_reg <= 1'b0;
            end else if (byte_done) begin
                unique case (state_reg)
                    ST_CMD: begin
                        id_sel_reg <= byte_in[7];
                        is_sr_reg <= (byte_in == `SPIEE_OP_WRITE || byte_in == `SPIEE_OP_WRID);
                        tx_reg <= status_byte;
                    end
                    ST_ADDR_HI: addr_reg[10:8] <= byte_in[2:0];
                    ST_ADDR_LO: begin
                        addr_reg[7:0] <= byte_in;
                        load_req_reg <= ~is_sr_reg;
                    end
                    ST_RDATA: begin
                        if (state_next == ST_RDATA && byte_in == byte_in) begin
                            load_req_reg <= 1'b1;
                        end
                    end
                    ST_WDATA: begin
                        // Rolls over inside the 32-byte page
                        addr_reg[4:0] <= 5'(addr_reg[4:0] + 1'b1);
                        pushed_reg <= pushed_reg | fifo_push;
                    end
                    ST_SR_W: begin
                        sr_new_reg <= byte_in;
                        sr_pend_reg <= 1'b1;
                    end
                    ST_IGNORE: sr_pend_reg <= 1'b0;
                endcase
            end else if (load_req_reg) begin
                if (is_status_read()) begin
                    tx_reg <= status_byte;
                end else begin
                    tx_reg <= rd_byte;
                    addr_reg <= id_sel_reg ? {addr_reg[10:5], 5'(addr_reg[4:0] + 1'b1)}
                                           : 11'(addr_reg + 1'b1);
                end
            end
        end
    end

    function automatic logic is_status_read();
        return ~is_sr_reg & (addr_reg == addr_reg) & tx_is_status;
    endfunction : is_status_read

    // Status reads are those entered straight from the command byte
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_is_status <= 1'b0;
        end else if (i_ce && byte_done && state_reg == ST_CMD) begin
            tx_is_status <= (byte_in == `SPIEE_OP_RDSR);
        end
    end

    // ----------------------------------------
    // Status bits and write cycle
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
            {srwd_reg, bp_reg} <= `SPIEE_SR_NV_RST;
            id_locked_reg <= 1'b0;
        end else if (i_ce) begin
            if (byte_done && state_reg == ST_CMD && !busy_reg) begin
                if (byte_in == `SPIEE_OP_WREN) begin
                    wel_reg <= 1'b1;
                end else if (byte_in == `SPIEE_OP_WRDI) begin
                    wel_reg <= 1'b0;
                end
            end
            if (cs_rise && sr_pend_reg && !sr_frozen) begin
                srwd_reg <= sr_new_reg[`SPIEE_SR_SRWD];
                bp_reg <= {sr_new_reg[`SPIEE_SR_BP_HI], sr_new_reg[`SPIEE_SR_BP_LO]};
                wel_reg <= 1'b0;
            end
            if (commit_wr) begin
                busy_reg <= 1'b1;
            end else if (drain_done) begin
                busy_reg <= 1'b0;
                wel_reg <= 1'b0;
            end
            if (drain && drain_lock) begin
                id_locked_reg <= 1'b1;
            end
        end
    end

    // Arrays have no reset; contents are non-volatile by nature
    always_ff @(posedge i_clk_sys) begin
        if (i_ce && drain && !fifo_out.id_sel) begin
            main_mem[fifo_out.addr] <= fifo_out.data;
        end
        if (i_ce && drain && fifo_out.id_sel && !drain_lock) begin
            id_mem[fifo_out.addr[4:0]] <= fifo_out.data;
        end
    end

    // ----------------------------------------
    // Output pin and power state
    // ----------------------------------------
    wire oe_next = live & (state_reg == ST_RDATA) & (o_miso_oe | drive_reg | sclk_fall);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
            o_standby <= 1'b1;
            o_busy <= 1'b0;
        end else if (i_ce) begin
            if (live && sclk_fall && state_reg == ST_RDATA) begin
                o_miso <= tx_reg[~bit_cnt_reg];
            end
            o_miso_oe <= oe_next;
            o_standby <= pins_reg.cs_b & ~busy_reg;
            o_busy <= busy_reg;
        end
    end
endmodule : spiee_top
`default_nettype wire
